// [verilog/scs_pkg.sv]
// package of constants and types for the sar conversion sequencer
package scs_pkg;
  localparam int unsigned SCS_CLK_MHZ = 50; // system clock rate
  localparam logic [4:0] SCS_NORMAL_TICKS = 5'h0D; // converter clocks of a normal conversion
  localparam logic [4:0] SCS_FIRST_TICKS = 5'h19; // converter clocks of the first conversion
  localparam logic [4:0] SCS_NORMAL_SH = 5'h01; // tick of sample-and-hold, normal
  localparam logic [4:0] SCS_FIRST_SH = 5'h0D; // tick of sample-and-hold, first
  localparam logic [2:0] SCS_SRC_FREE_RUN = 3'h0; // trigger select code for free running
  localparam logic [9:0] SCS_RESULT_RESET = 10'h000; // result value after reset
  localparam logic [5:0] SCS_CH_BANDGAP = 6'h1E; // single-ended bandgap code
  localparam logic [5:0] SCS_CH_GROUND = 6'h1F; // single-ended ground code
  localparam logic [1:0] SCS_REF_RESET = 2'h0; // applied reference after reset
  localparam logic [5:0] SCS_CH_RESET = 6'h00; // applied channel after reset

  typedef enum logic [1:0] {
    SCS_GAIN_BYPASS,
    SCS_GAIN_1X,
    SCS_GAIN_10X,
    SCS_GAIN_200X
  } scs_gain_t;

  typedef enum logic [1:0] {
    SCS_IDLE,
    SCS_WAIT_TICK,
    SCS_CONVERT
  } scs_state_t;

  // software-held configuration bits
  typedef struct packed {
    logic converter_enable;
    logic converter_power_reduction;
    logic left_adjust_select;
    logic auto_trigger_enable;
    logic [2:0] trigger_source_select;
    logic [2:0] prescale_select;
    logic [5:0] channel_select_bits;
    logic [1:0] reference_select_bits;
  } scs_cfg_t;

  // selection applied to the analog front end
  typedef struct packed {
    logic [5:0] channel;
    logic [1:0] reference;
    scs_gain_t gain;
    logic amp_bypass;
  } scs_sel_t;
endpackage

// [verilog/scs_sequencer.sv]
// conversion sequencer: prescaler, start and trigger control, result interlock
// Contract
// - result is 10 bits over two bytes, right aligned, left aligned when selected
// - reading the low byte blocks result updates until high byte read
// - a completion while blocked leaves both bytes unchanged, result discarded
// - reading the high byte re-enables result updates
// - completion flag still sets when the result is discarded
// - writing start begins a single conversion; start clears on completion
// - channel change during a conversion waits until it completes
// - auto trigger active when enabled; source chosen by trigger select
// - rising edge of selected trigger resets prescaler and starts a conversion
// - trigger still high at completion does not start another conversion
// - trigger edges during a conversion are ignored
// - free-running source restarts at each completion regardless of the flag
// - start write still launches a conversion while auto trigger enabled
// - start bit reads one during every conversion
// - channel and reference selections apply only while enabled
// - channel chosen from pins, ground, bandgap single-ended or differential pairs
// - four gain pairs offer 1x, 10x, 200x; single-ended bypasses amplifier
// - converter unusable while power reduction is set
// - prescaler runs while enabled, held in reset while disabled
// - software start begins on the next converter clock edge
// - conversion lasts 13 converter clocks, first after enable 25
// - completion writes result and sets flag; single mode clears start together
`timescale 1ns/1ps
module scs_sequencer
  import scs_pkg::*;
(
  input wire logic sys_clk, // system clock, 50 MHz
  input wire logic rstn, // asynchronous reset, active low
  input wire scs_cfg_t cfg, // control bits held by software
  input wire logic start_write, // pulse: software writes one to start bit
  input wire logic flag_clear_write, // pulse: software writes one to the flag
  input wire logic flag_vector_ack, // pulse: completion vector taken
  input wire logic low_read, // pulse: low result byte read
  input wire logic high_read, // pulse: high result byte read
  input wire logic [7:1] trigger_in, // trigger source levels, codes 1 to 7
  input wire logic [9:0] core_result, // value from the approximation core
  output logic [7:0] result_low_byte, // low result byte
  output logic [7:0] result_high_byte, // high result byte
  output logic start_conversion_bit, // start bit as read back
  output logic conversion_complete_flag, // sticky completion flag
  output logic writes_blocked, // result updates blocked
  output logic converter_clock, // prescaled converter clock tick
  output logic sample_hold, // pulse: sample-and-hold instant
  output logic core_capture, // pulse: core result written
  output scs_sel_t front_end // applied channel, reference and gain
);

  scs_state_t state;
  logic [6:0] presc_cnt;
  logic [4:0] tick_cnt;
  logic first_pending;
  logic start_req;
  logic trig_prev;
  logic [9:0] result;
  logic active;
  logic [7:0] presc_limit;
  logic tick;
  logic trig_level;
  logic trig_edge;
  logic auto_start;
  logic done;
  logic free_restart;
  logic [4:0] conv_len;
  logic [4:0] sh_tick;
  scs_sel_t next_front_end;

  // power reduction keeps the converter off whatever the enable says
  assign active = cfg.converter_enable & ~cfg.converter_power_reduction;

  // prescaler division 2 to 128
  assign presc_limit = (8'h01 << ((cfg.prescale_select == 3'h0) ? 3'h1 : cfg.prescale_select))
                       - 8'h01;
  assign tick = active && (presc_cnt == presc_limit[6:0]);
  assign converter_clock = tick;

  // trigger source selection and edge detection
  assign trig_level = (cfg.trigger_source_select == SCS_SRC_FREE_RUN) ? 1'b0 :
                      trigger_in[cfg.trigger_source_select];
  assign trig_edge = trig_level & ~trig_prev;
  assign auto_start = active && cfg.auto_trigger_enable &&
                      cfg.trigger_source_select != SCS_SRC_FREE_RUN &&
                      trig_edge && state == SCS_IDLE;

  assign conv_len = first_pending ? SCS_FIRST_TICKS : SCS_NORMAL_TICKS;
  assign sh_tick = first_pending ? SCS_FIRST_SH : SCS_NORMAL_SH;
  assign done = state == SCS_CONVERT && tick && tick_cnt == conv_len - 5'h01;
  assign free_restart = done && cfg.auto_trigger_enable &&
                        cfg.trigger_source_select == SCS_SRC_FREE_RUN;
  assign sample_hold = state == SCS_CONVERT && tick && tick_cnt == sh_tick;
  assign core_capture = done & ~writes_blocked;

  // start bit reads one for any pending or running conversion
  assign start_conversion_bit = start_req | (state != SCS_IDLE);

  // prescaler: held in reset while off, restarted by a trigger edge
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      presc_cnt <= 7'h00;
    end else if (!active || auto_start) begin
      presc_cnt <= 7'h00;
    end else if (tick) begin
      presc_cnt <= 7'h00;
    end else begin
      presc_cnt <= presc_cnt + 7'h01;
    end
  end

  // trigger level history, kept running so a held level never looks fresh
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_level;
    end
  end

  // software start request, held until the conversion begins
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      start_req <= 1'b0;
    end else if (!active) begin
      start_req <= 1'b0;
    end else if (start_write && state == SCS_IDLE && !auto_start) begin
      start_req <= 1'b1;
    end else if (state == SCS_WAIT_TICK && tick) begin
      start_req <= 1'b0;
    end
  end

  // conversion state machine
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= SCS_IDLE;
      tick_cnt <= 5'h00;
    end else if (!active) begin
      state <= SCS_IDLE;
      tick_cnt <= 5'h00;
    end else begin
      case (state)
        SCS_IDLE: begin
          tick_cnt <= 5'h00;
          if (auto_start) begin
            state <= SCS_CONVERT;
          end else if (start_req || start_write) begin
            state <= SCS_WAIT_TICK;
          end
        end
        SCS_WAIT_TICK: begin
          if (tick) begin
            state <= SCS_CONVERT;
          end
        end
        SCS_CONVERT: begin
          if (done) begin
            tick_cnt <= 5'h00;
            state <= free_restart ? SCS_CONVERT : SCS_IDLE;
          end else if (tick) begin
            tick_cnt <= tick_cnt + 5'h01;
          end
        end
        default: begin
          state <= SCS_IDLE;
        end
      endcase
    end
  end

  // first conversion after enabling runs long
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      first_pending <= 1'b1;
    end else if (!active) begin
      first_pending <= 1'b1;
    end else if (done) begin
      first_pending <= 1'b0;
    end
  end

  // read interlock between low and high result bytes
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      writes_blocked <= 1'b0;
    end else if (high_read) begin
      writes_blocked <= 1'b0;
    end else if (low_read) begin
      writes_blocked <= 1'b1;
    end
  end

  // result store, skipped while blocked
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      result <= SCS_RESULT_RESET;
    end else if (core_capture) begin
      result <= core_result;
    end
  end

  // alignment of the stored result onto the two bytes
  always_comb begin
    if (cfg.left_adjust_select) begin
      result_high_byte = result[9:2];
      result_low_byte = {result[1:0], 6'h00};
    end else begin
      result_high_byte = {6'h00, result[9:8]};
      result_low_byte = result[7:0];
    end
  end

  // completion flag: set wins over either clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      conversion_complete_flag <= 1'b0;
    end else if (done) begin
      conversion_complete_flag <= 1'b1;
    end else if (flag_clear_write || flag_vector_ack) begin
      conversion_complete_flag <= 1'b0;
    end
  end

  // decode of the selection the front end should see
  always_comb begin
    next_front_end.channel = cfg.channel_select_bits;
    next_front_end.reference = cfg.reference_select_bits;
    next_front_end.amp_bypass = 1'b0;
    next_front_end.gain = SCS_GAIN_1X;
    if (cfg.channel_select_bits[4:3] == 2'b00 || cfg.channel_select_bits == SCS_CH_BANDGAP ||
        cfg.channel_select_bits == SCS_CH_GROUND) begin
      next_front_end.amp_bypass = 1'b1;
      next_front_end.gain = SCS_GAIN_BYPASS;
    end else if (cfg.channel_select_bits[4:3] == 2'b01) begin
      case (cfg.channel_select_bits[2:1])
        2'b00: next_front_end.gain = SCS_GAIN_10X;
        2'b01: next_front_end.gain = SCS_GAIN_200X;
        default: next_front_end.gain = SCS_GAIN_1X;
      endcase
    end
  end

  // selection follows software only while enabled and between conversions
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      front_end <= '{channel: SCS_CH_RESET, reference: SCS_REF_RESET,
                     gain: SCS_GAIN_BYPASS, amp_bypass: 1'b1};
    end else if (active && (state != SCS_CONVERT || done)) begin
      front_end <= next_front_end;
    end
  end

  default clocking chk_cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_block_after_low: assert property (low_read && !high_read |=> writes_blocked)
    else $error("low byte read did not block result updates");
  chk_discard_blocked: assert property (done && writes_blocked |=> $stable(result))
    else $error("result changed while blocked");
  chk_unblock_high: assert property (high_read |=> !writes_blocked)
    else $error("high byte read did not unblock");
  chk_flag_on_done: assert property (done |=> conversion_complete_flag)
    else $error("flag not set on completion");
  chk_start_clears: assert property (done && !free_restart && !start_write
                                     |=> !start_conversion_bit)
    else $error("start bit not cleared at completion");
  chk_start_busy: assert property (state == SCS_CONVERT |-> start_conversion_bit)
    else $error("start bit low during conversion");
  chk_sel_locked: assert property (state == SCS_CONVERT && !done |=> $stable(front_end))
    else $error("selection changed mid conversion");
  chk_presc_off: assert property (!active |=> presc_cnt == 7'h00)
    else $error("prescaler ran while disabled");
  chk_auto_begin: assert property (auto_start |=> state == SCS_CONVERT && presc_cnt == 7'h00)
    else $error("trigger edge did not start at once");
  chk_edge_ignored: assert property (state == SCS_CONVERT && !done |=>
                                     state == SCS_CONVERT || !active)
    else $error("conversion broken by trigger edge");
  chk_free_run: assert property (free_restart && active |=> state == SCS_CONVERT)
    else $error("free running did not restart");
  chk_power_off: assert property (cfg.converter_power_reduction |=> state == SCS_IDLE)
    else $error("converter ran under power reduction");
  chk_sw_start: assert property (state == SCS_WAIT_TICK && tick && active
                                 |=> state == SCS_CONVERT)
    else $error("software start missed converter clock");

  cov_single: cover property (state == SCS_WAIT_TICK ##1 state == SCS_CONVERT [*2]);
  cov_discard: cover property (done && writes_blocked);
  cov_free_run: cover property (free_restart);
  cov_auto: cover property (auto_start);

endmodule

// [test/scs_core_model.sv]
// behavioural model of the multiplexer and approximation core; the applied gain is ignored
`timescale 1ns/1ps
module scs_core_model
  import scs_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic rstn, // asynchronous reset, active low
  input wire logic sample_hold, // sample instant from the sequencer
  input wire scs_sel_t front_end, // applied channel, reference and gain
  output logic [9:0] core_result // approximated value
);
  logic [3:0] samples;

  // value carries the sampled channel and the sample number, so lost results show
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      samples <= 4'h0;
      core_result <= 10'h3FF;
    end else if (sample_hold) begin
      samples <= samples + 4'h1;
      core_result <= {front_end.channel, samples + 4'h1};
    end
  end
endmodule

// [test/test_scs_sequencer.sv]
// testbench of the conversion sequencer with the core model on its far side
`timescale 1ns/1ps
module test_scs_sequencer;
  import scs_pkg::*;
  logic sys_clk, rstn;
  scs_cfg_t cfg;
  logic [4:0] pl; // start, flag clear, vector taken, low read, high read
  logic [7:1] trig;
  logic [9:0] core_result;
  logic [7:0] lo, hi;
  logic sbit, flag, blocked, cclk, sh, cap;
  scs_sel_t fe;
  logic [8:0] gt [5];
  int fail_count, compares, n, caps, ticks;

  scs_sequencer dut_u (.sys_clk(sys_clk), .rstn(rstn), .cfg(cfg), .start_write(pl[0]),
    .flag_clear_write(pl[1]), .flag_vector_ack(pl[2]), .low_read(pl[3]), .high_read(pl[4]),
    .trigger_in(trig), .core_result(core_result), .result_low_byte(lo), .result_high_byte(hi),
    .start_conversion_bit(sbit), .conversion_complete_flag(flag), .writes_blocked(blocked),
    .converter_clock(cclk), .sample_hold(sh), .core_capture(cap), .front_end(fe));
  scs_core_model core_u (.sys_clk(sys_clk), .rstn(rstn), .sample_hold(sh), .front_end(fe),
    .core_result(core_result));

  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask
  task automatic pulse(input int i);
    pl[i] = 1'b1;
    step(1);
    pl[i] = 1'b0;
  endtask
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t ns: expected %h got %h", $time, exp, got);
    end
  endtask
  // software start; the start bit must already read one
  task automatic launch();
    pulse(0);
    n = 1;
    chk(16'h0001, {15'h0, sbit});
  endtask
  // bounded wait for the start bit to fall, counting cycles in n
  task automatic wait_done();
    while (sbit === 1'b1 && n < 300) begin
      step(1);
      n++;
    end
  endtask
  task automatic final_report();
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // 50 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // watchdog well beyond the expected run of about 350 cycles
  initial begin
    #100000;
    fail_count++;
    final_report();
  end

  // main sequence
  initial begin
    rstn = 1'b0;
    pl = 5'h00;
    trig = 7'h00;
    cfg = '0;
    cfg.prescale_select = 3'h1;
    cfg.channel_select_bits = 6'h05;
    cfg.reference_select_bits = 2'h3;
    gt = '{{6'h08, SCS_GAIN_10X, 1'b0}, {6'h0A, SCS_GAIN_200X, 1'b0},
      {6'h0C, SCS_GAIN_1X, 1'b0}, {6'h1E, SCS_GAIN_BYPASS, 1'b1}, {6'h10, SCS_GAIN_1X, 1'b0}};
    step(4);
    rstn = 1'b1;
    chk(16'h0000, {hi, lo});
    chk(16'h0001, {5'h00, fe.reference, fe.channel, flag, sbit, fe.amp_bypass});
    pulse(0);
    step(2);
    chk(16'h0000, {15'h0, sbit});
    // enabled but held in power reduction: still unusable
    cfg.converter_enable = 1'b1;
    cfg.converter_power_reduction = 1'b1;
    pulse(0);
    step(2);
    chk(16'h0000, {9'h000, fe.channel, sbit});
    cfg.converter_power_reduction = 1'b0;
    // channel decode and gain stage selection
    for (int i = 0; i < 5; i++) begin
      cfg.channel_select_bits = gt[i][8:3];
      step(2);
      chk({7'h00, gt[i]}, {7'h00, fe.channel, fe.gain, fe.amp_bypass});
    end
    chk(16'h0003, {14'h0, fe.reference});
    // first conversion after enable, right then left aligned
    cfg.channel_select_bits = 6'h05;
    step(2);
    launch();
    wait_done();
    chk(16'h0001, {15'h0, n >= 50 && n <= 54});
    chk(16'h0051, {hi, lo});
    chk(16'h0001, {15'h0, flag});
    cfg.left_adjust_select = 1'b1;
    step(1);
    chk(16'h1440, {hi, lo});
    cfg.left_adjust_select = 1'b0;
    pulse(1);
    chk(16'h0000, {15'h0, flag});
    // low byte read blocks the next result, flag still rises
    pulse(3);
    launch();
    wait_done();
    chk(16'h0001, {15'h0, n >= 26 && n <= 30});
    chk(16'h0051, {hi, lo});
    chk(16'h0003, {14'h0, flag, blocked});
    pulse(4);
    chk(16'h0000, {15'h0, blocked});
    // channel change in mid conversion waits for completion
    launch();
    step(10);
    cfg.channel_select_bits = 6'h06;
    step(2);
    chk(16'h0005, {10'h000, fe.channel});
    wait_done();
    step(2);
    chk(16'h0053, {hi, lo});
    chk(16'h0006, {10'h000, fe.channel});
    // auto trigger from source 3; other lines and repeated edges do nothing
    pulse(1);
    cfg.auto_trigger_enable = 1'b1;
    cfg.trigger_source_select = 3'h3;
    trig[2] = 1'b1;
    step(4);
    chk(16'h0000, {15'h0, sbit});
    trig[3] = 1'b1;
    step(1);
    chk(16'h0001, {15'h0, sbit});
    step(6);
    trig[3] = 1'b0;
    step(2);
    trig[3] = 1'b1;
    n = 0;
    wait_done();
    chk(16'h0064, {hi, lo});
    step(40);
    chk(16'h0000, {15'h0, sbit});
    pulse(2);
    chk(16'h0000, {15'h0, flag});
    launch();
    wait_done();
    chk(16'h0065, {hi, lo});
    // free running: restarts at every completion without clearing the flag
    cfg.trigger_source_select = SCS_SRC_FREE_RUN;
    trig = 7'h00;
    launch();
    caps = 0;
    ticks = 0;
    repeat (100) begin
      step(1);
      if (cap === 1'b1) caps++;
      if (cclk === 1'b1) ticks++;
    end
    chk(16'h0001, {15'h0, caps >= 2 && sbit === 1'b1 && flag === 1'b1});
    chk(16'h0032, ticks[15:0]);
    cfg.converter_enable = 1'b0;
    step(2);
    chk(16'h0000, {15'h0, sbit});
    final_report();
  end
endmodule
